// ===== uibc_consts.svh
`ifndef UIBC_CONSTS_SVH
`define UIBC_CONSTS_SVH

// ==========================================================
// register byte addresses
`define UIBC_OFF_CTRL 16'hfd24
`define UIBC_OFF_STAT 16'hfd28
`define UIBC_OFF_TXD 16'hfd2c
`define UIBC_OFF_RXD 16'hfd30
`define UIBC_OFF_DIV 16'hfd34
`define UIBC_OFF_PSR 16'hfd38
`define UIBC_OFF_MODE 16'hfd3c
`define UIBC_OFF_EVT 16'hfd40
`define UIBC_OFF_MASK 16'hfd44

// ==========================================================
// one-hot select positions
`define UIBC_SEL_CTRL 0
`define UIBC_SEL_STAT 1
`define UIBC_SEL_TXD 2
`define UIBC_SEL_RXD 3
`define UIBC_SEL_DIV 4
`define UIBC_SEL_PSR 5
`define UIBC_SEL_MODE 6
`define UIBC_SEL_EVT 7
`define UIBC_SEL_MASK 8
`define UIBC_SEL_W 9

// ==========================================================
// field positions
`define UIBC_CTRL_TBE 0
`define UIBC_CTRL_RBF 1
`define UIBC_CTRL_EN_LO 5
`define UIBC_CTRL_EN_HI 7
`define UIBC_STAT_PAR 0
`define UIBC_STAT_FRM 1
`define UIBC_STAT_OVR 2
`define UIBC_STAT_ERR 3
`define UIBC_STAT_BUSY 6
`define UIBC_MODE_SYNC 0
`define UIBC_MODE_PAREN 1

// ==========================================================
// reset values (interrupt control reads 0x01)
`define UIBC_CTRL_RESET 8'h01
`define UIBC_TBE_RESET 1'b1

// ==========================================================
// timing: base ticks per bit are 16 async, 2 sync
`define UIBC_ASYNC_BIT_LAST 4'hf
`define UIBC_ASYNC_MID 4'h7
`define UIBC_SYNC_BIT_LAST 4'h1
`define UIBC_SYNC_MID 4'h0
`define UIBC_PRE_STEP 2
`define UIBC_FRAME_LAST 4'h9
`define UIBC_FRAME_LAST_PAR 4'ha

`endif

// ===== uibc_pkg.sv
package uibc_pkg;

    // ==========================================================
    // line-side state machines
    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } uibc_tx_state_type;

    typedef enum logic [0:0] {
        RX_IDLE = 1'b0,
        RX_FRAME = 1'b1
    } uibc_rx_state_type;

endpackage : uibc_pkg

// ===== uibc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uibc_consts.svh"

module uibc_top
    import uibc_pkg::*;
#(
    parameter int DIV_W = 11, // baud divisor width
    parameter int PSR_W = 5 // prescale select width
) (
    input wire logic pclk, // system clock, 20 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [15:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // unmapped address
    output logic irq, // level interrupt
    input wire logic rxd, // serial receive pin
    output logic txd, // serial transmit pin
    output logic sclk // serial clock, sync mode only
);

    // ==========================================================
    // state
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic txd;
        logic sclk;
        logic [2:0] irq_en; // fault, rx full, tx empty
        logic tx_empty_flag;
        logic rx_full_flag;
        logic parity_flag;
        logic framing_flag;
        logic overrun_flag;
        logic [DIV_W-1:0] divisor;
        logic [PSR_W-1:0] prescale_select;
        logic sync_mode;
        logic parity_en;
        logic [2:0] evt; // fault, rx full, tx empty
        logic [2:0] evt_mask;
        logic [7:0] tx_holding_buffer;
        uibc_tx_state_type tx_state;
        logic [10:0] tx_shift_register;
        logic [3:0] tx_left;
        logic [3:0] tx_tick;
        uibc_rx_state_type rx_state;
        logic [10:0] rx_shift_register;
        logic [3:0] rx_bits;
        logic [3:0] rx_tick;
        logic [7:0] rx_holding_buffer;
        logic [2:0] rx_sync;
        logic rx_level;
        logic [PSR_W:0] pre_acc;
        logic [DIV_W-1:0] div_cnt;
    } uibc_state_type;

    uibc_state_type s_q;
    uibc_state_type s_d;

    // ==========================================================
    // address decode, shared by read and write paths
    function automatic logic [`UIBC_SEL_W-1:0] reg_sel(input logic [15:0] a);
        logic [`UIBC_SEL_W-1:0] s;
        s = '0;
        case (a)
            `UIBC_OFF_CTRL: s[`UIBC_SEL_CTRL] = 1'b1;
            `UIBC_OFF_STAT: s[`UIBC_SEL_STAT] = 1'b1;
            `UIBC_OFF_TXD: s[`UIBC_SEL_TXD] = 1'b1;
            `UIBC_OFF_RXD: s[`UIBC_SEL_RXD] = 1'b1;
            `UIBC_OFF_DIV: s[`UIBC_SEL_DIV] = 1'b1;
            `UIBC_OFF_PSR: s[`UIBC_SEL_PSR] = 1'b1;
            `UIBC_OFF_MODE: s[`UIBC_SEL_MODE] = 1'b1;
            `UIBC_OFF_EVT: s[`UIBC_SEL_EVT] = 1'b1;
            `UIBC_OFF_MASK: s[`UIBC_SEL_MASK] = 1'b1;
            default: s = '0;
        endcase
        return s;
    endfunction : reg_sel

    // ==========================================================
    // next state
    always_comb begin
        logic [`UIBC_SEL_W-1:0] sel;
        logic capture;
        logic done;
        logic rd;
        logic wr;
        logic [31:0] rdata;
        logic [PSR_W:0] p2;
        logic [PSR_W:0] acc_sum;
        logic pre_tick;
        logic base_tick;
        logic [3:0] bit_last;
        logic [3:0] mid;
        logic [3:0] frame_last;
        logic err;
        logic perr;
        logic ferr;
        logic oerr;
        sel = reg_sel(paddr);
        capture = psel & penable & ~s_q.pready;
        done = psel & penable & s_q.pready;
        rd = capture & ~pwrite;
        wr = done & pwrite;
        rdata = '0;
        p2 = '0;
        acc_sum = '0;
        pre_tick = 1'b0;
        base_tick = 1'b0;
        err = 1'b0;
        perr = 1'b0;
        ferr = 1'b0;
        oerr = 1'b0;
        bit_last = '0;
        mid = '0;
        frame_last = '0;
        s_d = s_q;

        // read mux; reserved bits stay zero
        rdata[`UIBC_CTRL_TBE] = sel[`UIBC_SEL_CTRL] & s_q.tx_empty_flag;
        rdata[`UIBC_CTRL_RBF] = sel[`UIBC_SEL_CTRL] & s_q.rx_full_flag;
        if (sel[`UIBC_SEL_CTRL]) begin
            rdata[`UIBC_CTRL_EN_HI:`UIBC_CTRL_EN_LO] = s_q.irq_en;
        end
        if (sel[`UIBC_SEL_STAT]) begin
            rdata[`UIBC_STAT_PAR] = s_q.parity_flag;
            rdata[`UIBC_STAT_FRM] = s_q.framing_flag;
            rdata[`UIBC_STAT_OVR] = s_q.overrun_flag;
            rdata[`UIBC_STAT_ERR] = s_q.parity_flag | s_q.framing_flag
                | s_q.overrun_flag;
            rdata[`UIBC_STAT_BUSY] = (s_q.tx_state == TX_SEND);
        end
        if (sel[`UIBC_SEL_RXD]) begin
            rdata[7:0] = s_q.rx_holding_buffer;
        end
        if (sel[`UIBC_SEL_DIV]) begin
            rdata[DIV_W-1:0] = s_q.divisor;
        end
        if (sel[`UIBC_SEL_PSR]) begin
            rdata[PSR_W-1:0] = s_q.prescale_select;
        end
        if (sel[`UIBC_SEL_MODE]) begin
            rdata[`UIBC_MODE_SYNC] = s_q.sync_mode;
            rdata[`UIBC_MODE_PAREN] = s_q.parity_en;
        end
        if (sel[`UIBC_SEL_EVT]) begin
            rdata[2:0] = s_q.evt;
        end
        if (sel[`UIBC_SEL_MASK]) begin
            rdata[2:0] = s_q.evt_mask;
        end

        // apb answer: one wait state, data registered with pready
        s_d.pready = capture;
        s_d.pslverr = capture & ~(|sel);
        s_d.prdata = rd ? rdata : '0;

        // read side effects act at capture so a same-cycle set still wins
        if (rd && sel[`UIBC_SEL_STAT]) begin
            s_d.parity_flag = 1'b0;
            s_d.framing_flag = 1'b0;
            s_d.overrun_flag = 1'b0;
        end
        if (rd && sel[`UIBC_SEL_RXD]) begin
            s_d.rx_full_flag = 1'b0;
        end

        // software writes; flag bits of control are read-only
        if (wr && sel[`UIBC_SEL_CTRL]) begin
            s_d.irq_en = pwdata[`UIBC_CTRL_EN_HI:`UIBC_CTRL_EN_LO];
        end
        if (wr && sel[`UIBC_SEL_DIV]) begin
            s_d.divisor = pwdata[DIV_W-1:0];
            s_d.div_cnt = '0; // avoid a long wrap past a smaller divisor
        end
        if (wr && sel[`UIBC_SEL_PSR]) begin
            s_d.prescale_select = pwdata[PSR_W-1:0];
        end
        if (wr && sel[`UIBC_SEL_MODE]) begin
            s_d.sync_mode = pwdata[`UIBC_MODE_SYNC];
            s_d.parity_en = pwdata[`UIBC_MODE_PAREN];
        end
        if (wr && sel[`UIBC_SEL_EVT]) begin
            s_d.evt = s_q.evt & ~pwdata[2:0];
        end
        if (wr && sel[`UIBC_SEL_MASK]) begin
            s_d.evt_mask = pwdata[2:0];
        end

        // prescaler in half steps: P = (select + 2) / 2, so 6.5 is reachable
        p2 = (PSR_W+1)'(s_q.prescale_select) + (PSR_W+1)'(`UIBC_PRE_STEP);
        acc_sum = s_q.pre_acc + (PSR_W+1)'(`UIBC_PRE_STEP);
        pre_tick = (acc_sum >= p2);
        s_d.pre_acc = pre_tick ? acc_sum - p2 : acc_sum;

        // divisor: one base tick every N = divisor + 1 prescaler ticks
        if (pre_tick && !(wr && sel[`UIBC_SEL_DIV])) begin
            base_tick = (s_q.div_cnt == s_q.divisor);
            s_d.div_cnt = base_tick ? '0 : s_q.div_cnt + 1'b1;
        end

        // a bit lasts 16 base ticks async, 2 sync
        bit_last = s_q.sync_mode ? `UIBC_SYNC_BIT_LAST
            : `UIBC_ASYNC_BIT_LAST;
        mid = s_q.sync_mode ? `UIBC_SYNC_MID : `UIBC_ASYNC_MID;
        frame_last = s_q.parity_en ? `UIBC_FRAME_LAST_PAR : `UIBC_FRAME_LAST;

        // sync mode: serial clock toggles every base tick, one period per bit; async holds it high
        s_d.sclk = s_q.sync_mode ? (s_q.sclk ^ base_tick) : 1'b1;

        // transmitter: lsb first, even parity, one stop bit
        unique case (s_q.tx_state)
            TX_IDLE: begin
                if (!s_q.tx_empty_flag) begin
                    s_d.tx_shift_register = s_q.parity_en
                        ? {1'b1, ^s_q.tx_holding_buffer,
                           s_q.tx_holding_buffer, 1'b0}
                        : {2'b11, s_q.tx_holding_buffer, 1'b0};
                    s_d.tx_left = frame_last;
                    s_d.tx_tick = '0;
                    s_d.tx_state = TX_SEND;
                    s_d.tx_empty_flag = 1'b1;
                    s_d.evt[0] = 1'b1;
                end
            end
            TX_SEND: begin
                if (base_tick) begin
                    if (s_q.tx_tick == bit_last) begin
                        s_d.tx_tick = '0;
                        if (s_q.tx_left == 4'h0) begin
                            s_d.tx_state = TX_IDLE;
                        end else begin
                            s_d.tx_shift_register =
                                {1'b1, s_q.tx_shift_register[10:1]};
                            s_d.tx_left = s_q.tx_left - 4'h1;
                        end
                    end else begin
                        s_d.tx_tick = s_q.tx_tick + 4'h1;
                    end
                end
            end
        endcase

        // a new byte makes the holding buffer full even if a move just
        // emptied it, so the write is applied after the move
        if (wr && sel[`UIBC_SEL_TXD]) begin
            s_d.tx_holding_buffer = pwdata[7:0];
            s_d.tx_empty_flag = 1'b0;
        end
        s_d.txd = (s_d.tx_state == TX_SEND) ? s_d.tx_shift_register[0] : 1'b1;

        // pin filter: a level counts once the second and third stage agree
        s_d.rx_sync = {s_q.rx_sync[1:0], rxd};
        if (s_q.rx_sync[1] == s_q.rx_sync[2]) begin
            s_d.rx_level = s_q.rx_sync[2];
        end

        // receiver: start on low level, sample each bit in its middle
        unique case (s_q.rx_state)
            RX_IDLE: begin
                if (!s_q.rx_level) begin
                    s_d.rx_state = RX_FRAME;
                    s_d.rx_bits = '0;
                    s_d.rx_tick = '0;
                end
            end
            RX_FRAME: begin
                if (base_tick) begin
                    s_d.rx_tick = (s_q.rx_tick == bit_last) ? 4'h0
                        : s_q.rx_tick + 4'h1;
                    if (s_q.rx_tick == bit_last) begin
                        s_d.rx_bits = s_q.rx_bits + 4'h1;
                    end
                    if (s_q.rx_tick == mid) begin
                        s_d.rx_shift_register[s_q.rx_bits] = s_q.rx_level;
                        if (s_q.rx_bits == 4'h0 && s_q.rx_level) begin
                            s_d.rx_state = RX_IDLE; // glitch, not a start
                        end else if (s_q.rx_bits == frame_last) begin
                            // stop bit sampled: hand the byte over
                            ferr = ~s_q.rx_level;
                            perr = s_q.parity_en
                                & (^s_q.rx_shift_register[9:1]);
                            oerr = s_q.rx_full_flag
                                & ~(rd && sel[`UIBC_SEL_RXD]);
                            s_d.rx_state = RX_IDLE;
                            s_d.rx_holding_buffer = s_q.rx_shift_register[8:1];
                            s_d.rx_full_flag = 1'b1;
                            s_d.evt[1] = 1'b1;
                            if (ferr) begin
                                s_d.framing_flag = 1'b1;
                            end
                            if (perr) begin
                                s_d.parity_flag = 1'b1;
                            end
                            if (oerr) begin
                                s_d.overrun_flag = 1'b1;
                            end
                            if (ferr | perr | oerr) begin
                                s_d.evt[2] = 1'b1;
                            end
                        end
                    end
                end
            end
        endcase

        // interrupt level follows the flags of the next state
        err = s_d.overrun_flag | s_d.framing_flag | s_d.parity_flag;
        s_d.irq = (s_d.irq_en[0] & s_d.tx_empty_flag)
            | (s_d.irq_en[1] & s_d.rx_full_flag)
            | (s_d.irq_en[2] & err)
            | (|(s_d.evt & s_d.evt_mask));
    end

    // ==========================================================
    // state register; only constants under reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.tx_empty_flag <= `UIBC_TBE_RESET;
            s_q.txd <= 1'b1;
            s_q.sclk <= 1'b1;
            s_q.rx_sync <= 3'h7;
            s_q.rx_level <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irq = s_q.irq;
    assign txd = s_q.txd;
    assign sclk = s_q.sclk;

endmodule : uibc_top

`default_nettype wire

// ===== uibc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "uibc_consts.svh"

module uibc_chk (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [15:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic irq, // interrupt
    input wire logic rxd, // serial in
    input wire logic txd, // serial out
    input wire logic sclk // serial clock
);
    // ========
    // shadows of enables, mask and mode
    logic [2:0] en_q;
    logic [2:0] msk_q;
    logic sync_q;
    logic wr_done, ctl_rd, sta_rd;
    assign wr_done = psel && penable && pready && pwrite;
    assign ctl_rd = psel && penable && pready && !pwrite
        && (paddr == `UIBC_OFF_CTRL);
    assign sta_rd = psel && penable && pready && !pwrite
        && (paddr == `UIBC_OFF_STAT);
    // follow writes at the edge the design applies them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 3'h0;
            msk_q <= 3'h0;
            sync_q <= 1'b0;
        end else if (wr_done) begin
            if (paddr == `UIBC_OFF_CTRL) en_q <= pwdata[7:5];
            if (paddr == `UIBC_OFF_MASK) msk_q <= pwdata[2:0];
            if (paddr == `UIBC_OFF_MODE) sync_q <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========
    // properties
    property p_rst; $rose(presetn) |-> !irq && txd && sclk; endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    property p_rsvd;
        ctl_rd |-> prdata[4:2] == 3'h0 && prdata[31:8] == 24'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved set");
    property p_txi; ctl_rd && prdata[0] && prdata[5] |-> irq; endproperty
    a_txi: assert property (p_txi) else $error("no tx irq");
    property p_rxi; ctl_rd && prdata[1] && prdata[6] |-> irq; endproperty
    a_rxi: assert property (p_rxi) else $error("no rx irq");
    // the status read clears the flags at capture, so compare the level
    // that stood when the read data was taken
    property p_eri;
        sta_rd && prdata[3] && en_q[2] |-> $past(irq);
    endproperty
    a_eri: assert property (p_eri) else $error("no fault irq");
    property p_sum; sta_rd && prdata[2:0] != 3'h0 |-> prdata[3]; endproperty
    a_sum: assert property (p_sum) else $error("summary clear");
    property p_quiet;
        (en_q == 3'h0 && msk_q == 3'h0) [*3] |-> !irq;
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq unasked");
    property p_aclk; !sync_q [*2] |-> sclk; endproperty
    a_aclk: assert property (p_aclk) else $error("sclk moves");
endmodule : uibc_chk

bind uibc_top uibc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .rxd(rxd), .txd(txd), .sclk(sclk));
`default_nettype wire

// ===== uibc_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module uibc_far_end (
    input wire logic pclk, // system clock
    input wire logic txd, // line from the block
    input wire logic [15:0] bit_cyc, // clocks per bit
    output logic rxd, // line into the block
    output logic [7:0] got_byte, // decoded byte
    output logic got_stb // byte decoded, stop good
);
    initial begin
        rxd = 1'b1;
        got_stb = 1'b0;
        got_byte = 8'h00;
    end
    // ========
    // send a frame; a low stop makes a framing fault
    task automatic send(input logic [7:0] v, input logic stop);
        @(posedge pclk);
        rxd <= 1'b0;
        repeat (bit_cyc) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            rxd <= v[i];
            repeat (bit_cyc) @(posedge pclk);
        end
        rxd <= stop;
        repeat (bit_cyc) @(posedge pclk);
        rxd <= 1'b1;
        repeat (bit_cyc) @(posedge pclk);
    endtask : send
    // sample mid-bit, so a wrong bit time garbles the byte
    always begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge pclk);
        if (txd == 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(posedge pclk);
                got_byte[i] = txd;
            end
            repeat (bit_cyc) @(posedge pclk);
            got_stb = txd;
            @(posedge pclk);
            got_stb = 1'b0;
        end
    end
endmodule : uibc_far_end
`default_nettype wire

// ===== tb_usart_irq_flags_baud_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "uibc_consts.svh"

module tb_usart_irq_flags_baud_ctrl;
    logic pclk, presetn, psel, penable, pwrite, rxd, txd, sclk, irq;
    logic pready, pslverr, got_stb;
    logic [15:0] paddr, bit_cyc;
    logic [31:0] pwdata, prdata;
    logic [7:0] got_byte, b, b2;
    logic [32:0] exp_q[$];
    logic [7:0] txb_q[$];
    int err_count, checked, cyc, seed;

    uibc_top u_uibc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .rxd(rxd), .txd(txd), .sclk(sclk));
    uibc_far_end u_uibc_far_end (.pclk(pclk), .txd(txd), .bit_cyc(bit_cyc),
        .rxd(rxd), .got_byte(got_byte), .got_stb(got_stb));

    // ========
    // shared tasks
    task automatic check(input string nm, input logic [32:0] s,
        input logic [32:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic give_verdict;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // one apb transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd
    task automatic irq_is(input logic e);
        repeat (3) @(posedge pclk);
        check("irq", {32'h0, irq}, {32'h0, e});
    endtask : irq_is
    task automatic tx(input logic [7:0] v);
        txb_q.push_back(v);
        wr(`UIBC_OFF_TXD, {24'h0, v});
    endtask : tx

    // ========
    // clock, timeout and result watchers
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // a hang counts as a mismatch
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            give_verdict();
        end
    end
    // each finished transfer takes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready)
            check("apb", {pslverr, prdata}, exp_q.pop_front());
    end
    // each decoded frame takes the oldest sent byte
    always @(posedge got_stb) begin
        check("line", {25'h0, got_byte},
            {25'h0, txb_q.pop_front()});
    end

    // ========
    // main sequence, base tick every clock first
    initial begin
        seed = 93;
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        bit_cyc = 16'd16;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`UIBC_OFF_CTRL, 32'h01);
        irq_is(1'b0);
        // unmapped address answers with the error flag, read or write
        apb(1'b0, 16'hfd48, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 16'hfd48, 32'hff, {1'b1, 32'h0});
        wr(`UIBC_OFF_CTRL, 32'hff);
        rd(`UIBC_OFF_CTRL, 32'he1);
        wr(`UIBC_OFF_CTRL, 32'h20);
        irq_is(1'b1);
        tx(8'($random(seed)));
        tx(8'($random(seed)));
        rd(`UIBC_OFF_CTRL, 32'h20);
        irq_is(1'b0);
        repeat (200) @(posedge pclk);
        rd(`UIBC_OFF_CTRL, 32'h21);
        wr(`UIBC_OFF_CTRL, 32'h00);
        irq_is(1'b0);
        repeat (400) @(posedge pclk);
        wr(`UIBC_OFF_EVT, 32'h7);
        b = 8'($random(seed));
        u_uibc_far_end.send(b, 1'b1);
        rd(`UIBC_OFF_EVT, 32'h2);
        rd(`UIBC_OFF_CTRL, 32'h03);
        wr(`UIBC_OFF_MASK, 32'h2);
        irq_is(1'b1);
        wr(`UIBC_OFF_EVT, 32'h2);
        irq_is(1'b0);
        wr(`UIBC_OFF_MASK, 32'h0);
        wr(`UIBC_OFF_CTRL, 32'h40);
        rd(`UIBC_OFF_CTRL, 32'h43);
        rd(`UIBC_OFF_RXD, {24'h0, b});
        irq_is(1'b0);
        rd(`UIBC_OFF_CTRL, 32'h41);
        wr(`UIBC_OFF_CTRL, 32'h80);
        b2 = 8'($random(seed));
        u_uibc_far_end.send(b, 1'b1);
        u_uibc_far_end.send(b2, 1'b1);
        irq_is(1'b1);
        rd(`UIBC_OFF_STAT, 32'h0c);
        rd(`UIBC_OFF_STAT, 32'h00);
        irq_is(1'b0);
        rd(`UIBC_OFF_RXD, {24'h0, b2});
        u_uibc_far_end.send(b, 1'b0);
        rd(`UIBC_OFF_STAT, 32'h0a);
        rd(`UIBC_OFF_STAT, 32'h00);
        // parity on: the stop bit lands in the parity slot, so an even
        // data byte makes an odd frame and a parity fault
        rd(`UIBC_OFF_RXD, {24'h0, b});
        wr(`UIBC_OFF_MODE, 32'h2);
        u_uibc_far_end.send(b, 1'b1);
        rd(`UIBC_OFF_STAT, (^b) ? 32'h00 : 32'h09);
        rd(`UIBC_OFF_STAT, 32'h00);
        wr(`UIBC_OFF_MODE, 32'h0);
        // n 2 and p 6.5: 208 clocks a bit
        wr(`UIBC_OFF_DIV, 32'h1);
        wr(`UIBC_OFF_PSR, 32'd11);
        bit_cyc <= 16'd208;
        tx(8'($random(seed)));
        repeat (2400) @(posedge pclk);
        // sync mode only with whole p: n 3, p 2, 12 clocks a bit
        wr(`UIBC_OFF_DIV, 32'h2);
        wr(`UIBC_OFF_PSR, 32'h2);
        wr(`UIBC_OFF_MODE, 32'h1);
        bit_cyc <= 16'd12;
        tx(8'($random(seed)));
        // a base tick every 6 clocks: sclk flips once in any 6 edges
        b[0] = sclk;
        repeat (6) @(posedge pclk);
        check("sclk", {32'h0, sclk}, {32'h0, ~b[0]});
        repeat (300) @(posedge pclk);
        check("txq", {32'h0, txb_q.size() == 0}, 33'h1);
        give_verdict();
    end
endmodule : tb_usart_irq_flags_baud_ctrl
`default_nettype wire
